// ==== src/udr_consts.vh ====
// Constants for the DMA setup and interrupt register bank.
// Assumes inclusion by bare name from the design files of this block.
`ifndef UDR_CONSTS_VH
`define UDR_CONSTS_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define UDR_OFS_INT_STATUS   8'h18
`define UDR_OFS_DMA_REASON   8'h50
`define UDR_OFS_DMA_IRQ_EN   8'h54
`define UDR_OFS_DMA_EP_SEL   8'h58
`define UDR_OFS_DMA_BURST    8'h64

// ----------------------------------------
// Interrupt status fields
// ----------------------------------------
`define UDR_IS_BUS_RESET     0
`define UDR_IS_FRAME         1
`define UDR_IS_PSEUDO_FRAME  2
`define UDR_IS_SUSPEND       3
`define UDR_IS_RESUME        4
`define UDR_IS_HS_CHANGE     5
`define UDR_IS_DMA           6
`define UDR_IS_VBUS_RISE     7
`define UDR_IS_CTRL_SETUP    8
`define UDR_IS_EP_LSB        10
`define UDR_IS_EP_MSB        25
`define UDR_IS_VALID_MASK    32'h03fffdff
`define UDR_IS_RESET_VAL     32'h00000000
`define UDR_IS_BUS_RESET_FLAG_VAL    32'h00000001

// ----------------------------------------
// DMA reason and enable fields
// ----------------------------------------
`define UDR_DR_XFER_OK       8
`define UDR_DR_INT_END       10
`define UDR_DR_EXT_END       11
`define UDR_DR_STOP_DONE     12
`define UDR_DR_TEST          15
`define UDR_DR_CAUSE_MASK    16'h1d00
`define UDR_DE_RW_MASK       16'h1fff
`define UDR_DE_RESET_VAL     16'h0000

// ----------------------------------------
// DMA endpoint and burst fields
// ----------------------------------------
`define UDR_EP_DIR_BIT       0
`define UDR_EP_IDX_LSB       1
`define UDR_EP_IDX_MSB       3
`define UDR_EP_RESET_VAL     4'h0
`define UDR_BURST_W          13
`define UDR_BURST_RESET_VAL  13'h0002

`endif

// ==== src/udr_dma_reason.v ====
// DMA interrupt reason register with its change detection.
// Assumes cause pulses come from DMA engine logic on clk.
`timescale 1ns/1ps
module udr_dma_reason (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  input  wire        bus_reset,
  // Causes from the DMA engine
  input  wire        stop_cmd_done,
  input  wire        external_end_seen,
  input  wire        internal_end_seen,
  input  wire        transfer_complete,
  input  wire        short_transfer,
  // Register access
  input  wire        clear_wr,
  input  wire [15:0] clear_data,
  input  wire [15:0] irq_enable,
  // Results
  output wire [15:0] reason,
  output wire        dma_event
);
`include "udr_consts.vh"

  reg  [15:0] reason_r;
  reg  [15:0] reason_nxt;
  wire [15:0] set_vec;
  wire [15:0] clr_vec;

  assign set_vec = {short_transfer, 2'b00, stop_cmd_done, external_end_seen,
                    internal_end_seen, 1'b0, transfer_complete, 8'h00};
  assign clr_vec = clear_wr ? (clear_data & `UDR_DR_CAUSE_MASK) : 16'h0000;

  // ----------------------------------------
  // Cause bits
  // ----------------------------------------
  always @* begin
    reason_nxt = (reason_r & ~clr_vec) | set_vec;
    if (bus_reset) begin
      reason_nxt = 16'h0000;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      reason_r <= 16'h0000;
    end else begin
      reason_r <= reason_nxt;
    end
  end

  assign reason = reason_r;
  // Enable gates event
  // Only newly set causes count, so a clear alone never re-raises the summary
  assign dma_event = |(set_vec & ~reason_r & irq_enable & `UDR_DR_CAUSE_MASK) & ~bus_reset;

endmodule // udr_dma_reason

// ==== src/udr_dma_request_gen.v ====
// DMA request generator paced by the programmed burst length.
// Assumes level and acknowledge come from FIFO and DMA logic on clk.
`timescale 1ns/1ps
module udr_dma_request_gen #(
  parameter BW = 13
) (
  // Clock and reset
  input  wire          clk,
  input  wire          rst,
  input  wire          bus_reset,
  // Control
  input  wire          dma_active,
  input  wire [BW-1:0] burst_length,
  input  wire [BW-1:0] fifo_level,
  input  wire          dma_ack,
  // Request
  output wire          dma_request
);

  localparam S_IDLE  = 1'b0;
  localparam S_BURST = 1'b1;

  reg          state_r;
  reg          state_nxt;
  reg [BW-1:0] left_r;
  reg [BW-1:0] left_nxt;
  wire [BW-1:0] burst_eff;

  // Zero burst would never end; treat it as one
  assign burst_eff = (burst_length == {BW{1'b0}}) ? {{(BW-1){1'b0}}, 1'b1} : burst_length;

  // ----------------------------------------
  // Burst sequencing
  // ----------------------------------------
  always @* begin
    state_nxt = state_r;
    left_nxt  = left_r;
    case (state_r)
      S_IDLE: begin
        if (dma_active && (fifo_level >= burst_eff)) begin
          state_nxt = S_BURST;
          left_nxt  = burst_eff;
        end
      end
      S_BURST: begin
        if (dma_ack) begin
          left_nxt = left_r - {{(BW-1){1'b0}}, 1'b1};
          if (left_r == {{(BW-1){1'b0}}, 1'b1}) begin
            state_nxt = S_IDLE;
          end
        end
        if (!dma_active) begin
          state_nxt = S_IDLE;
        end
      end
      default: begin
        state_nxt = S_IDLE;
      end
    endcase
    if (bus_reset) begin
      state_nxt = S_IDLE;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      state_r <= S_IDLE;
      left_r  <= {BW{1'b0}};
    end else begin
      state_r <= state_nxt;
      left_r  <= left_nxt;
    end
  end

  assign dma_request = (state_r == S_BURST);

endmodule // udr_dma_request_gen

// ==== src/udr_regs.v ====
// Register bank for DMA setup and the main interrupt status.
// Assumes the register port and all event pulses are synchronous to clk.
`timescale 1ns/1ps
module udr_regs (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // USB bus reset event
  input  wire        bus_reset,
  // Register port
  input  wire [7:0]  reg_addr,
  input  wire        reg_wr,
  input  wire        reg_rd,
  input  wire [31:0] reg_wdata,
  output wire [31:0] reg_rdata,
  // Interrupt enables kept elsewhere
  input  wire [31:0] int_enable,
  output wire        irq,
  // Bus and endpoint events
  input  wire [7:0]  ep_tx_flag,
  input  wire [7:0]  ep_rx_flag,
  input  wire        ctrl_setup_flag,
  input  wire        vbus_rise_flag,
  input  wire        highspeed_change_flag,
  input  wire        resume_flag,
  input  wire        suspend_flag,
  input  wire        pseudo_frame_flag,
  input  wire        frame_flag,
  // DMA causes
  input  wire        stop_cmd_done,
  input  wire        external_end_seen,
  input  wire        internal_end_seen,
  input  wire        transfer_complete,
  input  wire        short_transfer,
  // DMA path control
  input  wire        dma_active,
  input  wire [12:0] fifo_level,
  input  wire        dma_ack,
  output wire [2:0]  dma_ep_select,
  output wire        dma_direction,
  output wire        dma_request
);
`include "udr_consts.vh"

  // ----------------------------------------
  // Storage
  // ----------------------------------------
  reg  [31:0] status_r;
  reg  [31:0] status_nxt;
  reg  [15:0] dma_en_r;
  reg  [3:0]  ep_sel_r;
  reg  [12:0] burst_r;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;
  wire [31:0] status_set;
  wire [15:0] ep_pairs;
  wire [15:0] reason;
  wire        dma_event;
  wire        wr_status;
  wire        wr_reason;
  wire        wr_dma_en;
  wire        wr_ep_sel;
  wire        wr_burst;

  // Address match, used for each register
  function hit;
    input [7:0] a;
    input [7:0] ofs;
    begin
      hit = (a == ofs);
    end
  endfunction

  assign wr_status = reg_wr & hit(reg_addr, `UDR_OFS_INT_STATUS);
  assign wr_reason = reg_wr & hit(reg_addr, `UDR_OFS_DMA_REASON);
  assign wr_dma_en = reg_wr & hit(reg_addr, `UDR_OFS_DMA_IRQ_EN);
  assign wr_ep_sel = reg_wr & hit(reg_addr, `UDR_OFS_DMA_EP_SEL);
  assign wr_burst  = reg_wr & hit(reg_addr, `UDR_OFS_DMA_BURST);

  // ----------------------------------------
  // Endpoint pair interleave
  // ----------------------------------------
  genvar g;
  generate
    for (g = 0; g < 8; g = g + 1) begin : g_ep
      assign ep_pairs[2*g]   = ep_rx_flag[g];
      assign ep_pairs[2*g+1] = ep_tx_flag[g];
    end
  endgenerate

  assign status_set = {6'h00, ep_pairs, 1'b0, ctrl_setup_flag,
                       vbus_rise_flag, dma_event, highspeed_change_flag, resume_flag,
                       suspend_flag, pseudo_frame_flag, frame_flag, 1'b0};

  // ----------------------------------------
  // DMA reason register
  // ----------------------------------------
  // Single summary source
  udr_dma_reason u_reason (
    .clk               (clk),
    .rst               (rst),
    .bus_reset         (bus_reset),
    .stop_cmd_done     (stop_cmd_done),
    .external_end_seen (external_end_seen),
    .internal_end_seen (internal_end_seen),
    .transfer_complete (transfer_complete),
    .short_transfer    (short_transfer),
    .clear_wr          (wr_reason),
    .clear_data        (reg_wdata[15:0]),
    .irq_enable        (dma_en_r),
    .reason            (reason),
    .dma_event         (dma_event)
  );

  // ----------------------------------------
  // Interrupt status
  // ----------------------------------------
  always @* begin
    status_nxt = status_r;
    if (wr_status) begin
      status_nxt = status_nxt & ~reg_wdata;
    end
    // Newly set enabled reason cause sets summary
    // Set after clear so an event in the clearing cycle survives
    status_nxt = (status_nxt | status_set) & `UDR_IS_VALID_MASK;
    if (bus_reset) begin
      status_nxt = `UDR_IS_BUS_RESET_FLAG_VAL;
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      status_r <= `UDR_IS_RESET_VAL;
    end else begin
      status_r <= status_nxt;
    end
  end

  assign irq = |(status_r & int_enable);

  // ----------------------------------------
  // DMA setup registers
  // ----------------------------------------
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_en_r <= `UDR_DE_RESET_VAL;
      ep_sel_r <= `UDR_EP_RESET_VAL;
      burst_r  <= `UDR_BURST_RESET_VAL;
    end else if (bus_reset) begin
      dma_en_r <= `UDR_DE_RESET_VAL;
      ep_sel_r <= `UDR_EP_RESET_VAL;
      burst_r  <= `UDR_BURST_RESET_VAL;
    end else begin
      if (wr_dma_en) begin
        dma_en_r <= reg_wdata[15:0] & `UDR_DE_RW_MASK;
      end
      if (wr_ep_sel) begin
        ep_sel_r <= reg_wdata[3:0];
      end
      if (wr_burst) begin
        burst_r <= reg_wdata[12:0];
      end
    end
  end

  assign dma_ep_select = ep_sel_r[`UDR_EP_IDX_MSB:`UDR_EP_IDX_LSB];
  assign dma_direction = ep_sel_r[`UDR_EP_DIR_BIT];

  // ----------------------------------------
  // DMA request pacing
  // ----------------------------------------
  // Overlap with the general endpoint index is not checked here; software owns it
  udr_dma_request_gen #(
    .BW (`UDR_BURST_W)
  ) u_dma_request (
    .clk          (clk),
    .rst          (rst),
    .bus_reset    (bus_reset),
    .dma_active   (dma_active),
    .burst_length (burst_r),
    .fifo_level   (fifo_level),
    .dma_ack      (dma_ack),
    .dma_request  (dma_request)
  );

  // ----------------------------------------
  // Read data
  // ----------------------------------------
  always @* begin
    rdata_nxt = rdata_r;
    if (reg_rd) begin
      case (reg_addr)
        `UDR_OFS_INT_STATUS: rdata_nxt = status_r;
        `UDR_OFS_DMA_REASON: rdata_nxt = {16'h0000, reason};
        `UDR_OFS_DMA_IRQ_EN: rdata_nxt = {16'h0000, dma_en_r};
        `UDR_OFS_DMA_EP_SEL: rdata_nxt = {28'h0000000, ep_sel_r};
        `UDR_OFS_DMA_BURST:  rdata_nxt = {19'h00000, burst_r};
        default:             rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always @(posedge clk or posedge rst) begin
    if (rst) begin
      rdata_r <= 32'h00000000;
    end else begin
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;

endmodule // udr_regs

// ==== sim/udr_regs_chk.sv ====
// Port checker for the DMA setup and interrupt register bank.
// Assumes it is bound onto udr_regs.
`timescale 1ns/1ps
module udr_regs_chk (
  // Clock and reset
  input wire        clk,
  input wire        rst,
  // Observed ports
  input wire        bus_reset,
  input wire [7:0]  reg_addr,
  input wire        reg_wr,
  input wire        reg_rd,
  input wire [31:0] reg_wdata,
  input wire [31:0] reg_rdata,
  input wire [31:0] int_enable,
  input wire        irq,
  input wire        frame_flag,
  input wire        dma_active,
  input wire [12:0] fifo_level,
  input wire        dma_ack,
  input wire [2:0]  dma_ep_select,
  input wire        dma_direction,
  input wire        dma_request
);
  default clocking @(posedge clk); endclocking
  default disable iff (rst);
  // ----
  // Properties
  // ----
  a_frame_irq: assert property (frame_flag && int_enable[1] && !bus_reset ##1 int_enable[1] |-> irq)
    else $error("frame event did not raise irq");
  a_bus_reset_flag_irq: assert property (bus_reset && int_enable[0] ##1 int_enable[0] |-> irq)
    else $error("bus reset did not raise irq");
  a_irq_gated: assert property (int_enable == 32'h0 |-> !irq)
    else $error("irq without any enable");
  a_ep_write: assert property (reg_wr && reg_addr == 8'h58 && !bus_reset |=>
    dma_ep_select == $past(reg_wdata[3:1]) && dma_direction == $past(reg_wdata[0]))
    else $error("endpoint select not taken from write");
  a_ep_bus_reset_flag: assert property (bus_reset |=> dma_ep_select == 3'h0 && !dma_direction)
    else $error("endpoint select kept over bus reset");
  a_burst_read: assert property (reg_rd && reg_addr == 8'h64 |=> reg_rdata[31:13] == 19'h0)
    else $error("burst reserved bits read nonzero");
  a_dma_request_idle: assert property (!dma_active |=> !dma_request)
    else $error("request without active dma");
  a_dma_request_hold: assert property (dma_request && dma_active && !dma_ack && !bus_reset |=> dma_request)
    else $error("request dropped without ack");
  a_dma_request_start: assert property ($rose(dma_request) |-> $past(dma_active) && $past(fifo_level) != 13'h0)
    else $error("request raised without data");
endmodule // udr_regs_chk

bind udr_regs udr_regs_chk chk_u (.clk, .rst, .bus_reset, .reg_addr, .reg_wr, .reg_rd, .reg_wdata,
  .reg_rdata, .int_enable, .irq, .frame_flag, .dma_active, .fifo_level, .dma_ack, .dma_ep_select,
  .dma_direction, .dma_request);

// ==== sim/udr_dma_peer.sv ====
// DMA controller model that acknowledges burst words.
// Assumes dma_request is an active high level on clk.
`timescale 1ns/1ps
module udr_dma_peer (
  // Clock and reset
  input  wire        clk,
  input  wire        rst,
  // DMA handshake
  input  wire        dma_request,
  output reg         dma_ack,
  output reg  [15:0] ack_count
);
  // Acknowledged words, counted over all bursts
  // Acks every other cycle: a slow peer, never counts an ack that comes after the request dropped
  always @(posedge clk or posedge rst) begin
    if (rst) begin
      dma_ack   <= 1'b0;
      ack_count <= 16'h0;
    end else begin
      dma_ack <= dma_request && !dma_ack;
      if (dma_ack && dma_request)
        ack_count <= ack_count + 16'h1;
    end
  end
endmodule // udr_dma_peer

// ==== sim/udr_regs_tb_top.sv ====
// Self-checking bench for the register bank.
// Assumes udr_regs, the checker and the DMA peer model are compiled first.
`timescale 1ns/1ps
module udr_regs_tb_top;
  logic        clk        = 1'b0;
  logic        rst        = 1'b1;
  logic        bus_reset  = 1'b0;
  logic [7:0]  reg_addr   = 8'h0;
  logic        reg_wr     = 1'b0;
  logic        reg_rd     = 1'b0;
  logic [31:0] reg_wdata  = 32'h0;
  logic [31:0] int_enable = 32'h0;
  logic [8:0]  sev        = 9'h0;
  logic [7:0]  ep_tx      = 8'h0;
  logic [7:0]  ep_rx      = 8'h0;
  logic [3:0]  dc         = 4'h0;
  logic        short_tr   = 1'b0;
  logic        dma_active = 1'b0;
  logic [12:0] fifo_level = 13'h0;
  logic [15:0] acks0;
  wire  [31:0] reg_rdata;
  wire  [2:0]  dma_ep_select;
  wire  [15:0] ack_count;
  wire         irq, dma_direction, dma_request, dma_ack;
  int          err_count  = 0;
  int          cmp_count  = 0;
  int          cyc        = 0;

  always #10 clk = ~clk;

  udr_regs dut_u (.clk(clk), .rst(rst), .bus_reset(bus_reset), .reg_addr(reg_addr), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata), .int_enable(int_enable), .irq(irq),
    .ep_tx_flag(ep_tx), .ep_rx_flag(ep_rx), .ctrl_setup_flag(sev[8]), .vbus_rise_flag(sev[7]),
    .highspeed_change_flag(sev[5]), .resume_flag(sev[4]), .suspend_flag(sev[3]),
    .pseudo_frame_flag(sev[2]), .frame_flag(sev[1]), .stop_cmd_done(dc[0]), .external_end_seen(dc[1]),
    .internal_end_seen(dc[2]), .transfer_complete(dc[3]), .short_transfer(short_tr), .dma_active(dma_active),
    .fifo_level(fifo_level), .dma_ack(dma_ack), .dma_ep_select(dma_ep_select),
    .dma_direction(dma_direction), .dma_request(dma_request));
  udr_dma_peer peer_u (.clk(clk), .rst(rst), .dma_request(dma_request), .dma_ack(dma_ack),
    .ack_count(ack_count));

  // ----
  // Tasks, entered just after a falling edge except conclude when the hang guard calls it on a rising edge
  // ----
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    reg_addr  = a;
    reg_wdata = d;
    reg_wr    = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
    // Idle cycle so a following access never re-raises a strobe in the same step
    @(negedge clk);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] exp);
    reg_addr = a;
    reg_rd   = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, exp);
    @(negedge clk);
  endtask
  task automatic ev(input logic [8:0] s, input logic [7:0] tx, input logic [7:0] rx, input logic [3:0] c);
    sev   = s;
    ep_tx = tx;
    ep_rx = rx;
    dc    = c;
    @(negedge clk);
    {sev, ep_tx, ep_rx, dc} = 29'h0;
    @(negedge clk);
  endtask
  task automatic conclude;
    $display("comparisons %0d mismatches %0d", cmp_count, err_count);
    if (err_count == 0 && cmp_count > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  // Hang guard, far above the few hundred cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 4000) begin
      err_count++;
      conclude();
    end
  end

  // ----
  // Tests
  // ----
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'b0;
    @(negedge clk);
    rd(8'h18, 32'h0);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0);
    rd(8'h64, 32'h2);
    rd(8'h20, 32'h0);
    wr(8'h54, 32'hffff);
    rd(8'h54, 32'h1fff);
    wr(8'h58, 32'hb);
    rd(8'h58, 32'hb);
    chk({29'h0, dma_ep_select}, 32'h5);
    chk({31'h0, dma_direction}, 32'h1);
    wr(8'h64, 32'hffffffff);
    rd(8'h64, 32'h1fff);
    $display("test 1 done");
    ev(9'h1be, 8'hff, 8'hff, 4'h0);
    chk({31'h0, irq}, 32'h0);
    rd(8'h18, 32'h03fffdbe);
    int_enable = 32'h2;
    @(negedge clk);
    chk({31'h0, irq}, 32'h1);
    chk(reg_rdata & int_enable, 32'h2);
    wr(8'h18, 32'h0);
    rd(8'h18, 32'h03fffdbe);
    wr(8'h18, 32'h03fffdbe);
    rd(8'h18, 32'h0);
    chk({31'h0, irq}, 32'h0);
    for (int n = 0; n < 8; n++) begin
      ev(9'h0, 8'h0, 8'h1 << n, 4'h0);
      ev(9'h0, 8'h1 << n, 8'h0, 4'h0);
      rd(8'h18, 32'h3 << (10 + 2 * n));
      wr(8'h18, 32'h3 << (10 + 2 * n));
    end
    ev(9'h2, 8'h0, 8'h0, 4'h0);
    chk({31'h0, irq}, 32'h1);
    wr(8'h18, 32'h2);
    $display("test 2 done");
    wr(8'h54, 32'h1d00);
    for (int k = 0; k < 4; k++) begin
      ev(9'h0, 8'h0, 8'h0, 4'h1 << k);
      rd(8'h50, 32'h1 << (k == 3 ? 8 : 12 - k));
      wr(8'h50, 32'h1 << (k == 3 ? 8 : 12 - k));
      rd(8'h50, 32'h0);
    end
    rd(8'h18, 32'h40);
    wr(8'h18, 32'h40);
    rd(8'h18, 32'h0);
    wr(8'h54, 32'h0);
    ev(9'h0, 8'h0, 8'h0, 4'h2);
    rd(8'h50, 32'h800);
    rd(8'h18, 32'h0);
    // Short transfer bit is status only: a write of one must not clear it
    short_tr = 1'b1;
    @(negedge clk);
    short_tr = 1'b0;
    @(negedge clk);
    wr(8'h50, 32'h8000);
    rd(8'h50, 32'h8800);
    rd(8'h18, 32'h0);
    $display("test 3 done");
    wr(8'h54, 32'h1d00);
    int_enable = 32'h3;
    bus_reset  = 1'b1;
    @(negedge clk);
    bus_reset = 1'b0;
    chk({31'h0, irq}, 32'h1);
    rd(8'h18, 32'h1);
    rd(8'h54, 32'h0);
    rd(8'h58, 32'h0);
    rd(8'h64, 32'h2);
    rd(8'h50, 32'h0);
    $display("test 4 done");
    // Even burst lengths that divide a 64-byte buffer
    for (int b = 2; b <= 4; b += 2) begin
      wr(8'h64, 32'(b));
      acks0      = ack_count;
      fifo_level = 13'(b - 1);
      dma_active = 1'b1;
      repeat (3) @(negedge clk);
      chk({31'h0, dma_request}, 32'h0);
      fifo_level = 13'(b);
      for (int i = 0; i < 20 && dma_request !== 1'b1; i++)
        @(negedge clk);
      fifo_level = 13'h0;
      for (int i = 0; i < 40 && dma_request !== 1'b0; i++)
        @(negedge clk);
      chk({16'h0, ack_count - acks0}, 32'(b));
      chk({31'h0, dma_request}, 32'h0);
      dma_active = 1'b0;
      @(negedge clk);
    end
    wr(8'h58, 32'he);
    chk({29'h0, dma_ep_select}, 32'h7);
    chk({31'h0, dma_direction}, 32'h0);
    $display("test 5 done");
    conclude();
  end
endmodule // udr_regs_tb_top
